// [common/kbi_pkg.sv]
package kbi_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] STAT_CTRL_ADDR = 8'h00;
  localparam logic [7:0] KEY_EN_ADDR = 8'h04;

  // ****************************************************************
  // Status and control fields
  // ****************************************************************
  localparam int EXT_MASK_POS = 0;
  localparam int EXT_MODE_POS = 1;
  localparam int EXT_ACK_POS = 2;
  localparam int EXT_PEND_POS = 3;
  localparam int KEY_MASK_POS = 4;
  localparam int KEY_MODE_POS = 5;
  localparam int KEY_ACK_POS = 6;
  localparam int KEY_PEND_POS = 7;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
  localparam logic PIN_IDLE = 1'b1;
  localparam logic BIT_CLEAR = 1'b0;

endpackage : kbi_pkg

// [logic/key_ext_irq_unit.sv]
// The implementer's own choices: the address map and the APB register port.
`timescale 1ns/100ps
`default_nettype none
module key_ext_irq_unit
#(
  parameter int KEY_PINS = 6
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_irq_pin_b,
  input wire logic [KEY_PINS-1:0] key_pins,
  input wire logic vector_fetch,
  input wire logic break_state,
  input wire logic break_clear_enable,
  output logic ext_irq_req,
  output logic key_irq_req,
  output logic [KEY_PINS-1:0] key_pin_enables
);

  // ****************************************************************
  // Parameter check
  // ****************************************************************
  if (KEY_PINS < 1 || KEY_PINS > 32)
  begin : g_bad_pins
    $error("KEY_PINS must lie in 1 to 32");
  end

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [1:0] ext_sync_q;
  logic ext_prev_q;
  logic [KEY_PINS-1:0] key_sync1_q;
  logic [KEY_PINS-1:0] key_sync2_q;
  logic key_low_prev_q;
  logic [2:0] settle_q;
  logic settled;
  logic ext_low;
  logic ext_fall;
  logic key_low;
  logic key_fall;
  logic ext_latch_q;
  logic ext_latch_d;
  logic ext_pend_q;
  logic ext_pend_d;
  logic key_latch_q;
  logic key_latch_d;
  logic key_pend_q;
  logic key_pend_d;
  logic ext_irq_mask_q;
  logic ext_trigger_sel_q;
  logic key_irq_mask_q;
  logic key_trigger_sel_q;
  logic [KEY_PINS-1:0] key_pin_enables_q;
  logic ext_req_q;
  logic key_req_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic setup;
  logic wr_access;
  logic wr_stat;
  logic ack_allowed;
  logic ext_ack;
  logic key_ack;
  logic addr_ok;
  logic [31:0] rdata_mux;

  // Returns {ack pending, latch} for one source
  function automatic logic [1:0] latch_next(
    input logic latch,
    input logic pend,
    input logic fall,
    input logic low,
    input logic mode,
    input logic ack
  );
    logic set;
    logic hold;
    logic clr;
    logic nxt;
    set = fall | (mode & low);
    hold = mode & low;
    clr = (ack | pend) & !hold;
    nxt = set | (latch & !clr);
    latch_next = {!fall & hold & (ack | pend) & nxt, nxt};
  endfunction : latch_next

  // ****************************************************************
  // Pin synchronisers and edge detection
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ext_sync_q <= {2{kbi_pkg::PIN_IDLE}};
      ext_prev_q <= kbi_pkg::PIN_IDLE;
      key_sync1_q <= {KEY_PINS{kbi_pkg::PIN_IDLE}};
      key_sync2_q <= {KEY_PINS{kbi_pkg::PIN_IDLE}};
      key_low_prev_q <= kbi_pkg::BIT_CLEAR;
    end
    else
    begin
      ext_sync_q <= {ext_sync_q[0], ext_irq_pin_b};
      ext_prev_q <= ext_sync_q[1];
      key_sync1_q <= key_pins;
      key_sync2_q <= key_sync1_q;
      key_low_prev_q <= key_low;
    end
  end

  // External pin edges ignored until every sync stage holds a real pin sample; key edges are not gated
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      settle_q <= '0;
    end
    else
    begin
      settle_q <= {settle_q[1:0], !kbi_pkg::BIT_CLEAR};
    end
  end

  assign settled = settle_q[2];
  assign ext_low = !ext_sync_q[1];
  assign ext_fall = ext_prev_q & ext_low & settled;
  // Only enabled pins take part in the combined level
  assign key_low = |(~key_sync2_q & key_pin_enables_q);
  assign key_fall = key_low & !key_low_prev_q;

  // ****************************************************************
  // Acknowledge decode
  // ****************************************************************
  assign setup = psel & !penable;
  assign wr_access = psel & penable & pwrite & pready_q;
  assign wr_stat = wr_access & (paddr == kbi_pkg::STAT_CTRL_ADDR);
  assign ack_allowed = !break_state | break_clear_enable;
  assign ext_ack = vector_fetch
    | (wr_stat & pwdata[kbi_pkg::EXT_ACK_POS] & ack_allowed);
  assign key_ack = vector_fetch
    | (wr_stat & pwdata[kbi_pkg::KEY_ACK_POS] & ack_allowed);

  // ****************************************************************
  // Interrupt latches
  // ****************************************************************
  always_comb
  begin
    {ext_pend_d, ext_latch_d} = latch_next(ext_latch_q, ext_pend_q, ext_fall, ext_low,
                                           ext_trigger_sel_q, ext_ack);
    {key_pend_d, key_latch_d} = latch_next(key_latch_q, key_pend_q, key_fall, key_low,
                                           key_trigger_sel_q, key_ack);
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ext_latch_q <= kbi_pkg::BIT_CLEAR;
      ext_pend_q <= kbi_pkg::BIT_CLEAR;
      key_latch_q <= kbi_pkg::BIT_CLEAR;
      key_pend_q <= kbi_pkg::BIT_CLEAR;
    end
    else
    begin
      ext_latch_q <= ext_latch_d;
      ext_pend_q <= ext_pend_d;
      key_latch_q <= key_latch_d;
      key_pend_q <= key_pend_d;
    end
  end

  // ****************************************************************
  // Control register fields
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ext_irq_mask_q <= kbi_pkg::BIT_CLEAR;
      ext_trigger_sel_q <= kbi_pkg::BIT_CLEAR;
      key_irq_mask_q <= kbi_pkg::BIT_CLEAR;
      key_trigger_sel_q <= kbi_pkg::BIT_CLEAR;
      key_pin_enables_q <= '0;
    end
    else
    begin
      if (wr_stat)
      begin
        ext_irq_mask_q <= pwdata[kbi_pkg::EXT_MASK_POS];
        ext_trigger_sel_q <= pwdata[kbi_pkg::EXT_MODE_POS];
        key_irq_mask_q <= pwdata[kbi_pkg::KEY_MASK_POS];
        key_trigger_sel_q <= pwdata[kbi_pkg::KEY_MODE_POS];
      end
      if (wr_access && paddr == kbi_pkg::KEY_EN_ADDR)
      begin
        key_pin_enables_q <= pwdata[KEY_PINS-1:0];
      end
    end
  end

  // ****************************************************************
  // Requests to the CPU priority logic
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ext_req_q <= kbi_pkg::BIT_CLEAR;
      key_req_q <= kbi_pkg::BIT_CLEAR;
    end
    else
    begin
      ext_req_q <= ext_latch_q & !ext_irq_mask_q;
      key_req_q <= key_latch_q & !key_irq_mask_q;
    end
  end

  // ****************************************************************
  // APB slave
  // ****************************************************************
  assign addr_ok = (paddr == kbi_pkg::STAT_CTRL_ADDR) || (paddr == kbi_pkg::KEY_EN_ADDR);

  always_comb
  begin
    rdata_mux = kbi_pkg::RDATA_RESET;
    if (paddr == kbi_pkg::STAT_CTRL_ADDR)
    begin
      rdata_mux[kbi_pkg::EXT_MASK_POS] = ext_irq_mask_q;
      rdata_mux[kbi_pkg::EXT_MODE_POS] = ext_trigger_sel_q;
      rdata_mux[kbi_pkg::EXT_PEND_POS] = ext_latch_q;
      rdata_mux[kbi_pkg::KEY_MASK_POS] = key_irq_mask_q;
      rdata_mux[kbi_pkg::KEY_MODE_POS] = key_trigger_sel_q;
      rdata_mux[kbi_pkg::KEY_PEND_POS] = key_latch_q;
    end
    else if (paddr == kbi_pkg::KEY_EN_ADDR)
    begin
      rdata_mux[KEY_PINS-1:0] = key_pin_enables_q;
    end
  end

  // Answer in the first access cycle; read data caught at setup
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pready_q <= kbi_pkg::BIT_CLEAR;
      pslverr_q <= kbi_pkg::BIT_CLEAR;
      prdata_q <= kbi_pkg::RDATA_RESET;
    end
    else
    begin
      pready_q <= setup;
      pslverr_q <= setup & !addr_ok;
      if (setup && !pwrite)
      begin
        prdata_q <= rdata_mux;
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign ext_irq_req = ext_req_q;
  assign key_irq_req = key_req_q;
  assign key_pin_enables = key_pin_enables_q;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_ext_edge_sets;
    @(posedge clk) disable iff (!rst_b)
    $fell(ext_sync_q[1]) && settled |=> ext_latch_q;
  endproperty
  a_ext_edge_sets: assert property (p_ext_edge_sets) else $error("ext edge not latched");

  property p_fetch_clears_edge;
    @(posedge clk) disable iff (!rst_b)
    vector_fetch && !ext_trigger_sel_q && !key_trigger_sel_q && !ext_fall && !key_fall
      |=> !ext_latch_q && !key_latch_q;
  endproperty
  a_fetch_clears_edge: assert property (p_fetch_clears_edge)
    else $error("fetch left latch");

  property p_ext_ack_clears;
    @(posedge clk) disable iff (!rst_b)
    wr_stat && pwdata[kbi_pkg::EXT_ACK_POS] && !break_state && !ext_trigger_sel_q && !ext_fall
      |=> !ext_latch_q;
  endproperty
  a_ext_ack_clears: assert property (p_ext_ack_clears) else $error("ext ack failed");

  property p_key_ack_clears;
    @(posedge clk) disable iff (!rst_b)
    wr_stat && pwdata[kbi_pkg::KEY_ACK_POS] && !break_state && !key_trigger_sel_q && !key_fall
      |=> !key_latch_q;
  endproperty
  a_key_ack_clears: assert property (p_key_ack_clears) else $error("key ack failed");

  property p_ext_level_holds;
    @(posedge clk) disable iff (!rst_b)
    ext_trigger_sel_q && ext_low |=> ext_latch_q;
  endproperty
  a_ext_level_holds: assert property (p_ext_level_holds)
    else $error("level latch dropped");

  property p_key_level_holds;
    @(posedge clk) disable iff (!rst_b)
    key_trigger_sel_q && key_low |=> key_latch_q;
  endproperty
  a_key_level_holds: assert property (p_key_level_holds)
    else $error("key level dropped");

  property p_mask_gates;
    @(posedge clk) disable iff (!rst_b)
    ##1 ext_req_q == ($past(ext_latch_q) && !$past(ext_irq_mask_q));
  endproperty
  a_mask_gates: assert property (p_mask_gates) else $error("mask gating wrong");

  property p_break_protect;
    @(posedge clk) disable iff (!rst_b)
    break_state && !break_clear_enable && !vector_fetch && ext_latch_q |=> ext_latch_q;
  endproperty
  a_break_protect: assert property (p_break_protect)
    else $error("latch cleared in break");

  property p_pend_read;
    @(posedge clk) disable iff (!rst_b)
    setup && !pwrite && paddr == kbi_pkg::STAT_CTRL_ADDR
      |=> prdata[kbi_pkg::EXT_PEND_POS] == $past(ext_latch_q)
          && !prdata[kbi_pkg::EXT_ACK_POS] && !prdata[kbi_pkg::KEY_ACK_POS];
  endproperty
  a_pend_read: assert property (p_pend_read) else $error("status read wrong");

  property p_key_pend_read;
    @(posedge clk) disable iff (!rst_b)
    setup && !pwrite && paddr == kbi_pkg::STAT_CTRL_ADDR
      |=> prdata[kbi_pkg::KEY_PEND_POS] == $past(key_latch_q);
  endproperty
  a_key_pend_read: assert property (p_key_pend_read)
    else $error("key pending read wrong");

  property p_ext_level_clears;
    @(posedge clk) disable iff (!rst_b)
    ext_trigger_sel_q && ext_pend_q && !ext_low |=> !ext_latch_q;
  endproperty
  a_ext_level_clears: assert property (p_ext_level_clears)
    else $error("level ack not applied");

  property p_key_edge_sets;
    @(posedge clk) disable iff (!rst_b)
    key_fall |=> key_latch_q;
  endproperty
  a_key_edge_sets: assert property (p_key_edge_sets)
    else $error("key edge not latched");

  property p_key_stays_clear;
    @(posedge clk) disable iff (!rst_b)
    !key_trigger_sel_q && !key_fall && !key_latch_q |=> !key_latch_q;
  endproperty
  a_key_stays_clear: assert property (p_key_stays_clear)
    else $error("key latch set without edge");

  property p_no_false_edge;
    @(posedge clk) disable iff (!rst_b)
    !settled && !ext_trigger_sel_q |=> !ext_latch_q;
  endproperty
  a_no_false_edge: assert property (p_no_false_edge)
    else $error("request after reset");

endmodule : key_ext_irq_unit
`default_nettype wire

// [tb/key_switch_model.sv]
`timescale 1ns/100ps
`default_nettype none
module key_switch_model
(
  input wire logic clk,
  input wire logic ext_low,
  input wire logic [5:0] key_press,
  input wire logic [5:0] key_en,
  input wire logic ext_req,
  input wire logic key_req,
  input wire logic glob_mask,
  output logic ext_irq_pin_b,
  output logic [5:0] key_pins,
  output logic cpu_irq,
  output logic [15:0] vec_addr
);
  // ****************************************************************
  // Switch levels
  // ****************************************************************
  logic [5:0] float_q = 6'h15;
  // Pins without pullup float, shown as a toggling pattern
  always_ff @(posedge clk)
  begin
    float_q <= ~float_q;
  end
  assign ext_irq_pin_b = ~ext_low;
  assign key_pins = (key_en & ~key_press) | (~key_en & float_q);

  // ****************************************************************
  // CPU side
  // ****************************************************************
  localparam logic [15:0] VEC_ADDR = 16'hfffa;
  localparam logic [15:0] NO_VEC = 16'h0000;
  // Global mask hides every request; handler taken from the fixed pair
  assign cpu_irq = (ext_req | key_req) & ~glob_mask;
  assign vec_addr = cpu_irq ? VEC_ADDR : NO_VEC;
endmodule : key_switch_model
`default_nettype wire

// [tb/external_keyboard_interrupt_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module external_keyboard_interrupt_tb;
  logic clk, rst_b, psel, penable, pwrite, pready, pslverr, rerr;
  logic vector_fetch, break_state, break_clear_enable, ext_low, glob_mask, cpu_irq;
  logic [15:0] vec_addr;
  logic ext_irq_pin_b, ext_irq_req, key_irq_req;
  logic [7:0] paddr, lfsr_q;
  logic [31:0] pwdata, prdata, rdat;
  logic [5:0] key_pins, key_pin_enables, key_press, en;
  int errors, n_tests, cycles;
  localparam logic [31:0] EM = 32'h0000_0001 << kbi_pkg::EXT_MASK_POS;
  localparam logic [31:0] EMD = 32'h0000_0001 << kbi_pkg::EXT_MODE_POS;
  localparam logic [31:0] EA = 32'h0000_0001 << kbi_pkg::EXT_ACK_POS;
  localparam logic [31:0] KMD = 32'h0000_0001 << kbi_pkg::KEY_MODE_POS;
  localparam logic [31:0] KM = 32'h0000_0001 << kbi_pkg::KEY_MASK_POS;
  localparam logic [31:0] KA = 32'h0000_0001 << kbi_pkg::KEY_ACK_POS;
  localparam logic [31:0] ZERO = 32'h0000_0000;
  localparam logic [31:0] ONE = 32'h0000_0001;
  localparam logic [7:0] KE = kbi_pkg::KEY_EN_ADDR;

  key_ext_irq_unit dut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_irq_pin_b(ext_irq_pin_b), .key_pins(key_pins),
    .vector_fetch(vector_fetch), .break_state(break_state),
    .break_clear_enable(break_clear_enable), .ext_irq_req(ext_irq_req),
    .key_irq_req(key_irq_req), .key_pin_enables(key_pin_enables));
  key_switch_model sw (.clk(clk), .ext_low(ext_low), .key_press(key_press),
    .key_en(key_pin_enables), .ext_req(ext_irq_req), .key_req(key_irq_req),
    .glob_mask(glob_mask), .ext_irq_pin_b(ext_irq_pin_b), .key_pins(key_pins),
    .cpu_irq(cpu_irq), .vec_addr(vec_addr));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  always #2.5 clk = ~clk;
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      errors++;
      report_and_stop;
    end
  end
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  // Flags: ext mask, ext mode, ext pending, key pending
  function automatic logic [31:0] st(input logic [3:0] f);
    st = ZERO;
    st[kbi_pkg::EXT_MASK_POS] = f[3];
    st[kbi_pkg::EXT_MODE_POS] = f[2];
    st[kbi_pkg::EXT_PEND_POS] = f[1];
    st[kbi_pkg::KEY_PEND_POS] = f[0];
  endfunction : st
  task report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : report_and_stop
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e)
    begin
      errors++;
      $display("MISMATCH %0t seen %h exp %h", $time, s, e);
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    @(posedge clk);
    while (pready !== 1'h1)
    begin
      @(posedge clk);
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task wr(input logic [31:0] d);
    apb(1'h1, kbi_pkg::STAT_CTRL_ADDR, d);
  endtask : wr
  task rd;
    apb(1'h0, kbi_pkg::STAT_CTRL_ADDR, ZERO);
  endtask : rd
  task drv(input logic e, input logic [5:0] k);
    @(posedge clk);
    ext_low <= e;
    key_press <= k;
  endtask : drv
  task ctl(input logic v, input logic b, input logic c);
    @(posedge clk);
    vector_fetch <= v;
    break_state <= b;
    break_clear_enable <= c;
  endtask : ctl

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial
  begin
    clk = 1'h0;
    rst_b = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = ZERO;
    vector_fetch = 1'h0;
    break_state = 1'h0;
    break_clear_enable = 1'h0;
    ext_low = 1'h0;
    glob_mask = 1'h0;
    key_press = 6'h00;
    lfsr_q = 8'h18;
    repeat (4) @(posedge clk);
    rst_b <= 1'h1;
    rd;
    chk(rdat, ZERO);
    apb(1'h0, KE, ZERO);
    chk(rdat, ZERO);
    chk(32'({ext_irq_req, key_irq_req}), ZERO);
    $display("end reset values");
    drv(1'h1, 6'h00);
    cyc(6);
    chk(32'(ext_irq_req), ONE);
    rd;
    chk(rdat, st(4'h2));
    wr(EM);
    cyc(2);
    chk(32'(ext_irq_req), ZERO);
    rd;
    chk(rdat, st(4'ha));
    wr(EM | EA);
    rd;
    chk(rdat, st(4'h8));
    wr(EMD);
    cyc(6);
    chk(32'(ext_irq_req), ONE);
    wr(EMD | EA);
    cyc(4);
    chk(32'(ext_irq_req), ONE);
    drv(1'h0, 6'h00);
    cyc(6);
    chk(32'(ext_irq_req), ZERO);
    $display("end external modes");
    wr(ZERO);
    drv(1'h1, 6'h00);
    cyc(6);
    wr(EA);
    cyc(2);
    chk(32'(ext_irq_req), ZERO);
    drv(1'h0, 6'h00);
    cyc(3);
    drv(1'h1, 6'h00);
    cyc(6);
    chk(32'(ext_irq_req), ONE);
    ctl(1'h0, 1'h1, 1'h0);
    wr(EA);
    cyc(2);
    chk(32'(ext_irq_req), ONE);
    ctl(1'h0, 1'h1, 1'h1);
    wr(EA);
    ctl(1'h0, 1'h0, 1'h0);
    cyc(3);
    chk(32'(ext_irq_req), ZERO);
    $display("end break");
    lfsr_q = lfsr(lfsr_q);
    en = lfsr_q[5:0] | 6'h21;
    apb(1'h1, KE, 32'(en));
    apb(1'h0, KE, ZERO);
    chk(rdat, 32'(en));
    chk(32'(key_pin_enables), 32'(en));
    cyc(4);
    wr(KA);
    cyc(2);
    chk(32'(key_irq_req), ZERO);
    drv(1'h1, 6'h01);
    cyc(6);
    chk(32'(key_irq_req), ONE);
    rd;
    chk(rdat, st(4'h1));
    wr(KA);
    cyc(2);
    chk(32'(key_irq_req), ZERO);
    drv(1'h1, 6'h21);
    cyc(6);
    chk(32'(key_irq_req), ZERO);
    drv(1'h0, 6'h00);
    cyc(4);
    drv(1'h1, 6'h01);
    cyc(6);
    chk(32'({ext_irq_req, key_irq_req}), 32'h0000_0003);
    chk(32'({cpu_irq, vec_addr}), 32'h0001_fffa);
    @(posedge clk);
    glob_mask <= 1'h1;
    cyc(1);
    chk(32'({cpu_irq, vec_addr}), ZERO);
    @(posedge clk);
    glob_mask <= 1'h0;
    ctl(1'h1, 1'h0, 1'h0);
    ctl(1'h0, 1'h0, 1'h0);
    cyc(2);
    chk(32'({ext_irq_req, key_irq_req}), ZERO);
    wr(KMD);
    cyc(6);
    chk(32'(key_irq_req), ONE);
    wr(KMD | KA);
    cyc(3);
    chk(32'(key_irq_req), ONE);
    wr(KMD | KM);
    cyc(2);
    chk(32'(key_irq_req), ZERO);
    $display("end keyboard");
    wr(EMD | KMD);
    cyc(4);
    chk(32'({ext_irq_req, key_irq_req}), 32'h0000_0003);
    @(posedge clk);
    rst_b <= 1'h0;
    cyc(2);
    @(posedge clk);
    rst_b <= 1'h1;
    cyc(4);
    chk(32'({ext_irq_req, key_irq_req}), ZERO);
    rd;
    chk(rdat, ZERO);
    apb(1'h0, KE, ZERO);
    chk(rdat, ZERO);
    apb(1'h1, 8'h0c, 32'hffff_ffff);
    chk(32'(rerr), ONE);
    rd;
    chk(rdat, ZERO);
    apb(1'h0, 8'h08, ZERO);
    chk({rdat[30:0], rerr}, ONE);
    $display("end reset and unmapped");
    report_and_stop;
  end
endmodule : external_keyboard_interrupt_tb
`default_nettype wire
